// *** tmr8_counter.sv ***
`timescale 1ns/1ps
// Operation
// - Zero value raises bottom indication
// - All ones value is maximum
// - Top is 0xFF or compare A
// - Timer disabled unless power off bit clear
// - Count and compare registers eight bits
// - Flags visible, each masked individually
// - Overflow, match A, match B sources
// - Clock from prescaler or external pin
// - Clock select picks source and edge
// - Select zero stops the counter
// - Count register accessible any time
// - Processor write beats clear and count
// - Each tick clears, increments or decrements
// - Step by one, clear to zero
// - Top (0xFF only) and bottom indications generated
// - Mode field split over two controls
// - Continuous compare feeds waveform logic
// - Match sets flag, may request interrupt
// - Overflow flag set per mode
// - Flags clear on service or write one
// - Normal mode overflow on wrap
module tmr8_counter
  import tmr8_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // Power and control
  input  wire logic         timer_power_off_bit_i,
  input  wire tmr8_ctrl_a_t control_reg_a_i,
  input  wire tmr8_ctrl_b_t control_reg_b_i,
  // Clock sources
  input  wire logic         prescale_tick_i,
  input  wire logic         ext_count_pin_i,
  // Register writes
  input  wire logic         count_wr_i,
  input  wire logic [7:0]   count_wdata_i,
  input  wire logic         compare_a_wr_i,
  input  wire logic [7:0]   compare_a_wdata_i,
  input  wire logic         compare_b_wr_i,
  input  wire logic [7:0]   compare_b_wdata_i,
  input  wire logic         mask_wr_i,
  input  wire logic [2:0]   mask_wdata_i,
  input  wire logic         flag_wr_i,
  input  wire logic [2:0]   flag_wdata_i,
  input  wire logic [2:0]   irq_ack_i,
  // Status
  output logic [7:0]        count_value_o,
  output logic [7:0]        compare_a_o,
  output logic [7:0]        compare_b_o,
  output logic [2:0]        timer_flag_o,
  output logic [2:0]        timer_mask_o,
  output logic [2:0]        irq_req_o,
  output tmr8_ind_t         ind_o
);

  // ------------------------------------------------------------------
  // Pin synchroniser and clock select
  // ------------------------------------------------------------------
  logic [7:0] count_value_reg, count_value_next;
  logic [7:0] compare_a_reg, compare_a_next;
  logic [7:0] compare_b_reg, compare_b_next;
  logic [2:0] timer_flag_reg, timer_flag_next;
  logic [2:0] timer_mask_reg, timer_mask_next;
  logic       dir_down_reg, dir_down_next;
  logic       block_reg, block_next;
  logic [2:0] irq_reg, irq_next;
  tmr8_ind_t  ind_reg, ind_next;
  logic       pin_s1_reg, pin_s2_reg, pin_s3_reg;

  logic [2:0] waveform_mode_field;
  logic [2:0] clock_select_field;
  logic       timer_tick;
  logic [7:0] top_val;
  logic       at_top, at_bottom, match_a, match_b;

  // Pin only reaches logic after two flops
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= ext_count_pin_i;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign waveform_mode_field = {control_reg_b_i.waveform_mode_bit2,
                                control_reg_a_i.waveform_mode_lo};
  assign clock_select_field  = control_reg_b_i.clock_select_field;

  always_comb begin
    timer_tick = 1'b0;
    case (clock_select_field)
      CS_STOP:     timer_tick = 1'b0;
      CS_EXT_FALL: timer_tick = pin_s3_reg & ~pin_s2_reg;
      CS_EXT_RISE: timer_tick = ~pin_s3_reg & pin_s2_reg;
      default:     timer_tick = prescale_tick_i;
    endcase
    if (timer_power_off_bit_i)
      timer_tick = 1'b0;
  end

  // ------------------------------------------------------------------
  // Limits and compare
  // ------------------------------------------------------------------
  always_comb begin
    case (waveform_mode_field)
      WGM_CTC, WGM_PC_OCRA, WGM_FAST_OCR: top_val = compare_a_reg;
      default:                            top_val = CNT_MAX;
    endcase
  end

  assign at_top    = (count_value_reg == top_val);
  assign at_bottom = (count_value_reg == CNT_BOTTOM);
  assign match_a   = (count_value_reg == compare_a_reg);
  assign match_b   = (count_value_reg == compare_b_reg);

  // ------------------------------------------------------------------
  // Counter, flags and registers
  // ------------------------------------------------------------------
  always_comb begin
    logic [2:0] set_v;
    logic [2:0] clr_v;
    logic       pc_mode;
    logic       ovf_ev;
    set_v            = 3'h0;
    clr_v            = 3'h0;
    ovf_ev           = 1'b0;
    pc_mode          = (waveform_mode_field == WGM_PC_MAX) ||
                       (waveform_mode_field == WGM_PC_OCRA);
    count_value_next = count_value_reg;
    dir_down_next    = dir_down_reg;
    block_next       = block_reg;
    compare_a_next   = compare_a_wr_i ? compare_a_wdata_i : compare_a_reg;
    compare_b_next   = compare_b_wr_i ? compare_b_wdata_i : compare_b_reg;
    timer_mask_next  = mask_wr_i ? mask_wdata_i : timer_mask_reg;

    if (timer_tick) begin
      block_next = 1'b0;
      if (!block_reg) begin
        set_v[FLG_MA] = match_a;
        set_v[FLG_MB] = match_b;
      end
      if (pc_mode) begin
        if (!dir_down_reg && at_top) begin
          dir_down_next    = 1'b1;
          count_value_next = count_value_reg - CNT_STEP;
        end else if (dir_down_reg && at_bottom) begin
          dir_down_next    = 1'b0;
          ovf_ev           = 1'b1;
          count_value_next = count_value_reg + CNT_STEP;
        end else if (dir_down_reg) begin
          count_value_next = count_value_reg - CNT_STEP;
        end else begin
          count_value_next = count_value_reg + CNT_STEP;
        end
      end else begin
        dir_down_next = 1'b0;
        if (at_top) begin
          count_value_next = CNT_BOTTOM;
          // CTC flags overflow only at MAX wrap
          ovf_ev = (waveform_mode_field != WGM_CTC) ||
                   (count_value_reg == CNT_MAX);
        end else begin
          count_value_next = count_value_reg + CNT_STEP;
          // Count above a compare A top still wraps at MAX
          ovf_ev           = (count_value_reg == CNT_MAX);
        end
      end
    end
    set_v[FLG_OVF] = ovf_ev;

    // Write wins over any count step, and blocks next match
    if (count_wr_i) begin
      count_value_next = count_wdata_i;
      block_next       = 1'b1;
    end

    clr_v = irq_ack_i | (flag_wr_i ? flag_wdata_i : 3'h0);
    // New event wins over a simultaneous clear
    timer_flag_next = (timer_flag_reg & ~clr_v) | set_v;
    irq_next        = timer_flag_next & timer_mask_next;

    ind_next.top     = (count_value_next == CNT_MAX);
    ind_next.bottom  = (count_value_next == CNT_BOTTOM);
    ind_next.max     = (count_value_next == CNT_MAX);
    ind_next.match_a = (count_value_next == compare_a_next);
    ind_next.match_b = (count_value_next == compare_b_next);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      count_value_reg <= CNT_RESET;
      compare_a_reg   <= CNT_RESET;
      compare_b_reg   <= CNT_RESET;
      timer_flag_reg  <= FLAGS_RESET;
      timer_mask_reg  <= FLAGS_RESET;
      irq_reg         <= FLAGS_RESET;
      dir_down_reg    <= 1'b0;
      block_reg       <= 1'b0;
      ind_reg         <= IND_RESET;
    end else begin
      count_value_reg <= count_value_next;
      compare_a_reg   <= compare_a_next;
      compare_b_reg   <= compare_b_next;
      timer_flag_reg  <= timer_flag_next;
      timer_mask_reg  <= timer_mask_next;
      irq_reg         <= irq_next;
      dir_down_reg    <= dir_down_next;
      block_reg       <= block_next;
      ind_reg         <= ind_next;
    end
  end

  assign count_value_o = count_value_reg;
  assign compare_a_o   = compare_a_reg;
  assign compare_b_o   = compare_b_reg;
  assign timer_flag_o  = timer_flag_reg;
  assign timer_mask_o  = timer_mask_reg;
  assign irq_req_o     = irq_reg;
  assign ind_o         = ind_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_write_priority: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    count_wr_i |=> count_value_reg == $past(count_wdata_i))
    else $error("count write not taken");

  a_stopped_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (clock_select_field == CS_STOP && !count_wr_i) |=> $stable(count_value_reg))
    else $error("stopped counter moved");

  a_power_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_power_off_bit_i && !count_wr_i) |=> $stable(count_value_reg))
    else $error("powered-off counter moved");

  a_normal_wrap: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_tick && waveform_mode_field == WGM_NORMAL && !count_wr_i &&
     count_value_reg == CNT_MAX) |=>
      count_value_reg == CNT_BOTTOM && timer_flag_reg[FLG_OVF])
    else $error("normal wrap without overflow flag");

  a_step_one: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_tick && waveform_mode_field == WGM_NORMAL && !count_wr_i &&
     count_value_reg != CNT_MAX) |=>
      count_value_reg == $past(count_value_reg) + 8'h01)
    else $error("count step not one");

  a_ctc_clear: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_tick && waveform_mode_field == WGM_CTC && !count_wr_i &&
     count_value_reg == compare_a_reg) |=> count_value_reg == CNT_BOTTOM)
    else $error("ctc did not clear at compare A");

  a_match_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_tick && !block_reg && match_a) |=> timer_flag_reg[FLG_MA])
    else $error("match A flag not set");

  a_irq_gate: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    irq_req_o[FLG_MB] |-> timer_mask_reg[FLG_MB] && timer_flag_reg[FLG_MB])
    else $error("unmasked interrupt request");

  a_flag_clear: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (irq_ack_i[FLG_OVF] && !timer_tick) |=> !timer_flag_reg[FLG_OVF])
    else $error("overflow flag not cleared");

  a_bottom_ind: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ind_o.bottom == (count_value_reg == CNT_BOTTOM))
    else $error("bottom indication wrong");

  a_match_b_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_tick && !block_reg && match_b) |=> timer_flag_reg[FLG_MB])
    else $error("match B flag not set");

  a_blocked_match: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_tick && block_reg && !timer_flag_reg[FLG_MA]) |=>
      !timer_flag_reg[FLG_MA])
    else $error("blocked match still set flag A");

  a_pc_turn: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (timer_tick && !count_wr_i && dir_down_reg && at_bottom &&
     (waveform_mode_field == WGM_PC_MAX ||
      waveform_mode_field == WGM_PC_OCRA)) |=>
      timer_flag_reg[FLG_OVF] && count_value_reg == CNT_STEP)
    else $error("phase correct turn without overflow");

endmodule // tmr8_counter

// *** tmr8_pkg.sv ***
package tmr8_pkg;

  // ------------------------------------------------------------------
  // Counter limits
  // ------------------------------------------------------------------
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_RESET  = 8'h00;
  localparam logic [7:0] CNT_STEP   = 8'h01;

  // ------------------------------------------------------------------
  // Clock select codes
  // ------------------------------------------------------------------
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_PRESCALE = 3'h1;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // ------------------------------------------------------------------
  // Waveform modes
  // ------------------------------------------------------------------
  localparam logic [2:0] WGM_NORMAL   = 3'h0;
  localparam logic [2:0] WGM_PC_MAX   = 3'h1;
  localparam logic [2:0] WGM_CTC      = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_OCRA  = 3'h5;
  localparam logic [2:0] WGM_FAST_OCR = 3'h7;

  // Flag bit positions
  localparam int FLG_OVF = 0;
  localparam int FLG_MA  = 1;
  localparam int FLG_MB  = 2;
  localparam logic [2:0] FLAGS_RESET = 3'h0;

  // Control fields of the two control registers
  typedef struct packed {
    logic [1:0] waveform_mode_lo;
  } tmr8_ctrl_a_t;

  typedef struct packed {
    logic       waveform_mode_bit2;
    logic [2:0] clock_select_field;
  } tmr8_ctrl_b_t;

  // Indications towards waveform generation
  typedef struct packed {
    logic top;
    logic bottom;
    logic max;
    logic match_a;
    logic match_b;
  } tmr8_ind_t;

  // Zeroed counter equals both zeroed compares, so no false edge later
  localparam tmr8_ind_t IND_RESET = 5'h0B;

endpackage

// *** tmr8_tb.sv ***
`timescale 1ns/1ps
module testbench
  import tmr8_pkg::*;
  ;
  logic         clk     = 1'b0;
  logic         rst_n   = 1'b0;
  logic         pwr_off = 1'b0;
  tmr8_ctrl_a_t ctl_a   = '0;
  tmr8_ctrl_b_t ctl_b   = '0;
  logic         tck     = 1'b0;
  logic         ext_pin = 1'b0;
  logic         cnt_wr  = 1'b0;
  logic [7:0]   cnt_wd  = 8'h00;
  logic         ca_wr   = 1'b0;
  logic         cb_wr   = 1'b0;
  logic         msk_wr  = 1'b0;
  logic         flg_wr  = 1'b0;
  logic [7:0]   wd      = 8'h00;
  logic [2:0]   ack     = 3'h0;
  logic [7:0]   cnt;
  logic [7:0]   cmp_a;
  logic [7:0]   cmp_b;
  logic [2:0]   flg;
  logic [2:0]   msk;
  logic [2:0]   irq;
  tmr8_ind_t    ind;
  int           miscompares = 0;
  int           checks      = 0;

  always #25 clk = ~clk;

  tmr8_counter i_tmr8_counter (
    .ref_clk_i(clk), .rst_n_i(rst_n), .timer_power_off_bit_i(pwr_off),
    .control_reg_a_i(ctl_a), .control_reg_b_i(ctl_b),
    .prescale_tick_i(tck), .ext_count_pin_i(ext_pin),
    .count_wr_i(cnt_wr), .count_wdata_i(cnt_wd),
    .compare_a_wr_i(ca_wr), .compare_a_wdata_i(wd),
    .compare_b_wr_i(cb_wr), .compare_b_wdata_i(wd),
    .mask_wr_i(msk_wr), .mask_wdata_i(wd[2:0]),
    .flag_wr_i(flg_wr), .flag_wdata_i(wd[2:0]), .irq_ack_i(ack),
    .count_value_o(cnt), .compare_a_o(cmp_a), .compare_b_o(cmp_b),
    .timer_flag_o(flg), .timer_mask_o(msk), .irq_req_o(irq), .ind_o(ind));

  // ------------------------------------------------------------------
  // Shared drivers
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk) tck = 1'b1;
      @(negedge clk) tck = 1'b0;
    end
  endtask

  task automatic wr_cnt(input logic [7:0] d, input logic t);
    @(negedge clk);
    cnt_wr = 1'b1;
    cnt_wd = d;
    tck    = t;
    @(negedge clk);
    cnt_wr = 1'b0;
    tck    = 1'b0;
  endtask

  // Which: 0 compare A, 1 compare B, 2 mask, 3 flag clear, 4 ack
  task automatic wr(input int which, input logic [7:0] d);
    @(negedge clk);
    wd = d;
    case (which)
      0: ca_wr = 1'b1;
      1: cb_wr = 1'b1;
      2: msk_wr = 1'b1;
      3: flg_wr = 1'b1;
      default: ack = d[2:0];
    endcase
    @(negedge clk);
    {ca_wr, cb_wr, msk_wr, flg_wr, ack} = '0;
  endtask

  task automatic mode(input logic [2:0] m, input logic [2:0] s);
    @(negedge clk);
    ctl_a.waveform_mode_lo = m[1:0];
    ctl_b = {m[2], s};
  endtask

  task automatic pin_to(input logic v);
    @(negedge clk) ext_pin = v;
    repeat (8) @(negedge clk);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk(cnt, 8'h00);
    chk(cmp_a, 8'h00);
    chk(cmp_b, 8'h00);
    chk({2'h0, flg, msk}, 8'h00);
    chk({5'h00, irq}, 8'h00);
    chk({3'h0, ind}, 8'h0B);
  endtask

  task automatic t_overflow();
    wr(2, 8'h01);
    mode(WGM_NORMAL, CS_PRESCALE);
    wr_cnt(8'hFF, 1'b0);
    chk({7'h00, ind.max}, 8'h01);
    chk({7'h00, ind.top}, 8'h01);
    tick(1);
    chk(cnt, 8'h00);
    chk({5'h00, flg}, 8'h01);
    chk({5'h00, irq}, 8'h01);
    chk({7'h00, ind.bottom}, 8'h01);
    wr(3, 8'h01);
    chk({5'h00, flg}, 8'h00);
  endtask

  task automatic t_stop();
    wr_cnt(8'h40, 1'b0);
    mode(WGM_NORMAL, CS_STOP);
    tick(3);
    chk(cnt, 8'h40);
    mode(WGM_NORMAL, CS_PRESCALE);
    pwr_off = 1'b1;
    tick(3);
    chk(cnt, 8'h40);
    wr_cnt(8'h41, 1'b0);
    chk(cnt, 8'h41);
    pwr_off = 1'b0;
    tick(1);
    chk(cnt, 8'h42);
    wr_cnt(8'h80, 1'b1);
    chk(cnt, 8'h80);
  endtask

  task automatic t_match();
    wr(0, 8'h05);
    wr(1, 8'h07);
    chk({cmp_a[3:0], cmp_b[3:0]}, 8'h57);
    wr(3, 8'h07);
    wr(2, 8'h06);
    chk({5'h00, msk}, 8'h06);
    // Write of the count value masks the very next match
    wr_cnt(8'h05, 1'b0);
    tick(1);
    chk({5'h00, flg}, 8'h00);
    wr_cnt(8'h04, 1'b0);
    tick(1);
    chk({7'h00, ind.match_a}, 8'h01);
    tick(1);
    chk({5'h00, flg}, 8'h02);
    chk({5'h00, irq}, 8'h02);
    tick(1);
    chk({7'h00, ind.match_b}, 8'h01);
    tick(1);
    chk({5'h00, flg}, 8'h06);
    wr(4, 8'h02);
    chk({5'h00, flg}, 8'h04);
    wr(2, 8'h00);
    chk({5'h00, irq}, 8'h00);
  endtask

  task automatic t_modes();
    mode(WGM_CTC, CS_PRESCALE);
    wr(0, 8'h03);
    wr_cnt(8'h02, 1'b0);
    wr(3, 8'h07);
    tick(2);
    chk(cnt, 8'h00);
    chk({7'h00, flg[FLG_OVF]}, 8'h00);
    mode(WGM_PC_OCRA, CS_PRESCALE);
    wr_cnt(8'h02, 1'b0);
    tick(2);
    chk(cnt, 8'h02);
    tick(3);
    chk(cnt, 8'h01);
    chk({7'h00, flg[FLG_OVF]}, 8'h01);
    wr(4, 8'h01);
    chk({7'h00, flg[FLG_OVF]}, 8'h00);
  endtask

  task automatic t_fast();
    mode(WGM_FAST_OCR, CS_PRESCALE);
    wr(0, 8'h03);
    wr(3, 8'h07);
    wr_cnt(8'h03, 1'b0);
    tick(1);
    chk(cnt, 8'h00);
    chk({7'h00, flg[FLG_OVF]}, 8'h01);
    wr(3, 8'h07);
    mode(WGM_FAST_MAX, 3'h2);
    wr_cnt(8'hFF, 1'b0);
    tick(1);
    chk(cnt, 8'h00);
    mode(WGM_PC_MAX, CS_PRESCALE);
    wr_cnt(8'hFF, 1'b0);
    tick(1);
    chk(cnt, 8'hFE);
  endtask

  task automatic t_mid_reset();
    @(negedge clk) rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
  endtask

  task automatic t_ext();
    mode(WGM_NORMAL, CS_EXT_RISE);
    wr_cnt(8'h10, 1'b0);
    pin_to(1'b1);
    chk(cnt, 8'h11);
    pin_to(1'b0);
    chk(cnt, 8'h11);
    mode(WGM_NORMAL, CS_EXT_FALL);
    pin_to(1'b1);
    pin_to(1'b0);
    chk(cnt, 8'h12);
  endtask

  // ------------------------------------------------------------------
  // Sequence and verdict
  // ------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_overflow();
    t_stop();
    t_match();
    t_modes();
    t_fast();
    t_ext();
    t_mid_reset();
    complete_run();
  end

  // Whole run needs well under 500 cycles
  initial begin
    #(5000 * 50);
    miscompares++;
    complete_run();
  end
endmodule // testbench
